// ### hdl/fmsp_cfg.svh
`ifndef FMSP_CFG_SVH
`define FMSP_CFG_SVH

// Register word addresses on the plain register port
`define FMSP_ADDR_BUFFER   2'h0
`define FMSP_ADDR_CONTROL  2'h1
`define FMSP_ADDR_POWER    2'h2

// Field positions inside serial_control
`define FMSP_CTL_MODE_HI   7
`define FMSP_CTL_MODE_LO   6
`define FMSP_CTL_FILTER    5
`define FMSP_CTL_RX_EN     4
`define FMSP_CTL_TX_NINTH  3
`define FMSP_CTL_RX_NINTH  2
`define FMSP_CTL_TX_DONE   1
`define FMSP_CTL_RX_DONE   0

// Field position of baud_doubler inside power_control_reg
`define FMSP_PWR_DOUBLER   7

// Reset values
`define FMSP_BYTE_RESET    8'h00
`define FMSP_NINE_RESET    9'h000
`define FMSP_NINE_ONES     9'h1FF

// Machine-cycle phases: twelve clocks, index = (state-1)*2 + (phase-1)
`define FMSP_PH_S1P1       4'h0
`define FMSP_PH_S3P1       4'h4
`define FMSP_PH_S5P2       4'h9
`define FMSP_PH_S6P2       4'hB
`define FMSP_PH_LAST       4'hB

// Fixed-rate mode prescaler limits (oscillator/4 and /2 sample ticks)
`define FMSP_M2_LIM_SLOW   2'h3
`define FMSP_M2_LIM_FAST   2'h1

// Divide-by-16 bit timing
`define FMSP_DIV16_LAST    4'hF
`define FMSP_SMP_FIRST     4'h7
`define FMSP_SMP_SECOND    4'h8
`define FMSP_SMP_DECIDE    4'h9

// Shift-register patterns and bit counts
`define FMSP_M0_RX_INIT    8'hFE
`define FMSP_M0_TX_MARK    8'h01
`define FMSP_TX_LAST_M1    4'h7
`define FMSP_TX_LAST_M23   4'h8
`define FMSP_RX_LAST_M1    4'h9
`define FMSP_RX_LAST_M23   4'hA
`define FMSP_RX_NINTH_IDX  4'h9

`endif

// ### hdl/fmsp_pkg.sv
package fmsp_pkg;

  // Port operating modes, in mode-select bit order
  typedef enum logic [1:0] {
    FMSP_SHIFT,
    FMSP_UART8,
    FMSP_UART9_FIX,
    FMSP_UART9_VAR
  } fmsp_mode_t;

  // Transmit sequencer states
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_M0_WAIT,
    TX_M0_SEND,
    TX_U_WAIT,
    TX_U_START,
    TX_U_DATA,
    TX_U_STOP
  } fmsp_tx_t;

  // Receive sequencer states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_M0_ARM,
    RX_M0_RUN,
    RX_U_BIT
  } fmsp_rx_t;

endpackage : fmsp_pkg

// ### hdl/fmsp_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_cfg.svh"

module fmsp_timing (
  input  wire logic              clk,          // Oscillator clock
  input  wire logic              rst_b,        // Synchronous reset, low
  input  wire fmsp_pkg::fmsp_mode_t mode,      // Current port mode
  input  wire logic              baud_doubler, // Rate doubling bit
  input  wire logic              t1_ovf,       // Timer 1 overflow pulse
  output logic [3:0]             phase,        // Machine-cycle phase
  output logic                   sample_tick   // Sixteen-times bit tick
);
  import fmsp_pkg::*;

  logic [3:0] phase_q;   // Phase within the machine cycle
  logic [1:0] pre_q;     // Fixed-rate prescaler
  logic       ovf_div_q; // Halves timer overflows when not doubling

  wire [1:0] pre_lim  = baud_doubler ? `FMSP_M2_LIM_FAST : `FMSP_M2_LIM_SLOW;
  wire       pre_hit  = (pre_q == pre_lim);
  wire       ph_wrap  = (phase_q == `FMSP_PH_LAST);
  // Variable rate: tick = overflow * 2^doubler / 2
  wire       var_tick = t1_ovf & (baud_doubler | ovf_div_q);

  assign phase       = phase_q;
  assign sample_tick = (mode == FMSP_UART9_FIX) ? pre_hit :
                       (mode == FMSP_SHIFT)     ? 1'b0    : var_tick;

  ////////////////////////////////////////////////////////////////////////
  // Twelve-phase machine cycle, fixed at oscillator/12
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_q <= `FMSP_PH_S1P1;
    end else begin
      phase_q <= ph_wrap ? `FMSP_PH_S1P1 : phase_q + 4'h1;
    end
  end

  // Prescalers for the fixed and the timer-derived rates
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_q     <= 2'h0;
      ovf_div_q <= 1'b0;
    end else begin
      pre_q <= pre_hit ? 2'h0 : pre_q + 2'h1;
      if (t1_ovf) begin
        ovf_div_q <= ~ovf_div_q;
      end
    end
  end

endmodule : fmsp_timing

`default_nettype wire

// ### hdl/fmsp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "fmsp_cfg.svh"

// Behaviour
// - Full duplex; second byte may overwrite-lose
// - Buffer write loads transmit, read returns receive
// - Two select bits choose one of four modes
// - Mode 0: data on rxd, clock on txd
// - Mode 1: start, eight data, stop frame
// - Modes 2/3: start, nine data, stop
// - Mode 3 equals mode 2 except rate
// - Any buffer write starts a transmission
// - Reception start conditions per mode
// - Modes 2/3 filter drops ninth-bit-zero frames
// - Mode 1 filter needs valid stop bit
// - Receive enable gates reception
// - Received ninth bit field contents per mode
// - Transmit flag set by hardware, software clears
// - Receive flag set by hardware, software clears
// - Mode 2 rate oscillator/64 or /32
// - Modes 1/3 rate from Timer 1 overflow
// - Mode 0 write loads marker, send follows
// - Mode 0 clock waveform and right shifts
// - Mode 0 marker ends transmit, sets flag
// - Mode 0 receive loads 11111110 then runs
// - Mode 0 receive shifts left each cycle
// - Mode 0 receive ends on zero leftmost
// - Majority of samples 7,8,9; reject false start
// - UART transmit starts after divider rollover
module fmsp_port (
  input  wire logic       clk,       // Oscillator clock, 200 MHz
  input  wire logic       rst_b,     // Synchronous reset, low
  input  wire logic [1:0] reg_addr,  // Register word address
  input  wire logic [7:0] reg_wdata, // Register write data
  input  wire logic       reg_wr,    // Write strobe
  input  wire logic       reg_rd,    // Read strobe
  output logic [7:0]      reg_rdata, // Read data, cycle after strobe
  input  wire logic       t1_ovf,    // Timer 1 overflow pulse
  input  wire logic       rxd_in,    // Receive pin level
  output logic            rxd_out,   // Receive pin drive, mode 0
  output logic            rxd_oe_b,  // Receive pin enable, low drives
  output logic            txd,       // Transmit pin
  output logic            serial_irq // Serial interrupt request
);
  import fmsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic       mode_select_high_q; // Mode select, upper bit
  logic       mode_select_low_q;  // Mode select, lower bit
  logic       multiproc_filter_q; // Address-frame filter
  logic       rx_enable_q;        // Receive enable
  logic       tx_ninth_bit_q;     // Ninth bit to send
  logic       rx_ninth_bit_q;     // Ninth bit received
  logic       tx_done_flag_q;     // Transmit flag
  logic       rx_done_flag_q;     // Receive flag
  logic       baud_doubler_q;     // Rate doubler
  logic [7:0] rx_buf_q;           // Receive buffer, separate from tx
  logic [7:0] rdata_q;            // Registered read data

  logic [3:0] phase;              // Machine-cycle phase
  logic       sample_tick;        // Sixteen-times bit tick

  // Transmit side
  fmsp_tx_t   tx_st_q;            // Transmit state
  logic [8:0] tx_sr_q;            // Transmit shift register
  logic [3:0] tx_bit_q;           // Data bit index
  logic [3:0] tdiv_q;             // Transmit divide-by-16
  logic       tx_go_q;            // Rollover seen after write
  logic       tx_last_q;          // Mode 0 last shift done

  // Receive side
  fmsp_rx_t   rx_st_q;            // Receive state
  logic [8:0] rx_sr_q;            // Receive shift register
  logic [3:0] rx_idx_q;           // Bit index, 0 is start
  logic [3:0] rdiv_q;             // Receive divide-by-16
  logic [1:0] rsmp_q;             // Samples at states 7 and 8
  logic       rx_last_q;          // Mode 0 last shift done
  logic       m0_samp_q;          // Mode 0 pin sample
  logic       rx_meta_q;          // Synchroniser first stage
  logic       rx_pin_q;           // Synchronised pin
  logic       rx_prev_q;          // Pin level at previous tick

  logic       txd_q;              // Registered pin drives
  logic       rxd_out_q;
  logic       rxd_oe_b_q;

  // Majority of three samples for noise rejection
  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  // Bit reversal: mode 0 collects LSB at the left end
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = v[7 - i];
    end
  endfunction : rev8

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire [1:0]  mode_bits = {mode_select_high_q, mode_select_low_q};
  wire fmsp_mode_t mode = fmsp_mode_t'(mode_bits);
  wire        is_m0     = (mode == FMSP_SHIFT);
  wire        is_m1     = (mode == FMSP_UART8);

  wire wr_buf = reg_wr && (reg_addr == `FMSP_ADDR_BUFFER);
  wire wr_ctl = reg_wr && (reg_addr == `FMSP_ADDR_CONTROL);
  wire wr_pwr = reg_wr && (reg_addr == `FMSP_ADDR_POWER);

  wire [7:0] ctl_val = {mode_select_high_q, mode_select_low_q,
                        multiproc_filter_q, rx_enable_q, tx_ninth_bit_q,
                        rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
  wire [7:0] pwr_val = {baud_doubler_q, 7'h00};
  // Unmapped addresses read zero
  wire [7:0] rd_mux  = (reg_addr == `FMSP_ADDR_BUFFER)  ? rx_buf_q :
                       (reg_addr == `FMSP_ADDR_CONTROL) ? ctl_val  :
                       (reg_addr == `FMSP_ADDR_POWER)   ? pwr_val  :
                       `FMSP_BYTE_RESET;

  wire at_s1p1 = (phase == `FMSP_PH_S1P1);
  wire at_s5p2 = (phase == `FMSP_PH_S5P2);
  wire at_s6p2 = (phase == `FMSP_PH_S6P2);
  // Shift clock low from S3P1 up to S6P1
  wire clk_low = (phase >= `FMSP_PH_S3P1) && (phase <= `FMSP_PH_S5P2);

  wire troll   = sample_tick && (tdiv_q == `FMSP_DIV16_LAST);
  wire [3:0] tx_last_idx = is_m1 ? `FMSP_TX_LAST_M1 : `FMSP_TX_LAST_M23;
  wire m0_mark = (tx_sr_q[8:1] == `FMSP_M0_TX_MARK);
  // Flag set events
  wire set_ti  = (tx_st_q == TX_M0_SEND && tx_last_q && at_s1p1) ||
                 (tx_st_q == TX_U_DATA && troll &&
                  tx_bit_q == tx_last_idx);

  // UART bit decision at counter state 9
  wire rx_dec  = (rx_st_q == RX_U_BIT) && sample_tick &&
                 (rdiv_q == `FMSP_SMP_DECIDE);
  wire rx_bit  = maj3(rsmp_q[0], rsmp_q[1], rx_pin_q);
  wire [3:0] rx_last_idx = is_m1 ? `FMSP_RX_LAST_M1 : `FMSP_RX_LAST_M23;
  wire rx_end  = rx_dec && (rx_idx_q == rx_last_idx);
  wire [8:0] rx_shift = {rx_bit, rx_sr_q[8:1]};
  // Mode 1 ends on the stop bit; modes 2/3 ignore the stop bit
  wire [8:0] rx_frame = is_m1 ? rx_shift : rx_sr_q;
  // Lost if flag still set; filter checks ninth or stop bit
  wire rx_take = !rx_done_flag_q &&
                 (!multiproc_filter_q || rx_frame[8]);
  wire rx_fall = sample_tick && rx_prev_q && !rx_pin_q;
  wire set_ri  = (rx_st_q == RX_M0_RUN && rx_last_q && at_s1p1) ||
                 (rx_end && rx_take);

  assign reg_rdata  = rdata_q;
  assign txd        = txd_q;
  assign rxd_out    = rxd_out_q;
  assign rxd_oe_b   = rxd_oe_b_q;
  assign serial_irq = tx_done_flag_q | rx_done_flag_q;

  ////////////////////////////////////////////////////////////////////////
  // Rate generation: machine cycle and sample tick
  fmsp_timing u_timing (
    .clk          (clk),
    .rst_b        (rst_b),
    .mode         (mode),
    .baud_doubler (baud_doubler_q),
    .t1_ovf       (t1_ovf),
    .phase        (phase),
    .sample_tick  (sample_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control register; hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {mode_select_high_q, mode_select_low_q} <= 2'h0;
      multiproc_filter_q <= 1'b0;
      rx_enable_q        <= 1'b0;
      tx_ninth_bit_q     <= 1'b0;
      tx_done_flag_q     <= 1'b0;
      rx_done_flag_q     <= 1'b0;
      baud_doubler_q     <= 1'b0;
    end else begin
      if (wr_ctl) begin
        mode_select_high_q <= reg_wdata[`FMSP_CTL_MODE_HI];
        mode_select_low_q  <= reg_wdata[`FMSP_CTL_MODE_LO];
        multiproc_filter_q <= reg_wdata[`FMSP_CTL_FILTER];
        rx_enable_q        <= reg_wdata[`FMSP_CTL_RX_EN];
        tx_ninth_bit_q     <= reg_wdata[`FMSP_CTL_TX_NINTH];
      end
      tx_done_flag_q <= set_ti | (wr_ctl ? reg_wdata[`FMSP_CTL_TX_DONE]
                                         : tx_done_flag_q);
      rx_done_flag_q <= set_ri | (wr_ctl ? reg_wdata[`FMSP_CTL_RX_DONE]
                                         : rx_done_flag_q);
      if (wr_pwr) begin
        baud_doubler_q <= reg_wdata[`FMSP_PWR_DOUBLER];
      end
    end
  end

  // Read data stand one cycle after the read strobe, else zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= `FMSP_BYTE_RESET;
    end else begin
      rdata_q <= reg_rd ? rd_mux : `FMSP_BYTE_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit divider runs free so bit times follow it, not the write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tdiv_q <= 4'h0;
    end else if (sample_tick) begin
      tdiv_q <= tdiv_q + 4'h1;
    end
  end

  // Transmit sequencer; a write while busy restarts the frame
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_st_q   <= TX_IDLE;
      tx_sr_q   <= `FMSP_NINE_RESET;
      tx_bit_q  <= 4'h0;
      tx_go_q   <= 1'b0;
      tx_last_q <= 1'b0;
    end else if (wr_buf) begin
      // Mode 0 puts a marker one in the ninth position
      tx_sr_q   <= {is_m0 | tx_ninth_bit_q, reg_wdata};
      tx_st_q   <= is_m0 ? TX_M0_WAIT : TX_U_WAIT;
      tx_go_q   <= 1'b0;
      tx_last_q <= 1'b0;
      tx_bit_q  <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_M0_WAIT: begin
          // Send rises at the next S6P2 after the write
          if (at_s6p2) begin
            tx_st_q <= TX_M0_SEND;
          end
        end
        TX_M0_SEND: begin
          if (at_s6p2 && !tx_last_q) begin
            tx_sr_q   <= {1'b0, tx_sr_q[8:1]};
            tx_last_q <= m0_mark;
          end else if (at_s1p1 && tx_last_q) begin
            tx_st_q   <= TX_IDLE;
            tx_last_q <= 1'b0;
          end
        end
        TX_U_WAIT: begin
          if (troll) begin
            tx_go_q <= 1'b1;
          end else if (tx_go_q && at_s1p1) begin
            tx_st_q <= TX_U_START;
          end
        end
        TX_U_START: begin
          if (troll) begin
            tx_st_q <= TX_U_DATA;
          end
        end
        TX_U_DATA: begin
          if (troll) begin
            tx_sr_q  <= {1'b0, tx_sr_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == tx_last_idx) begin
              tx_st_q <= TX_U_STOP;
            end
          end
        end
        TX_U_STOP: begin
          if (troll) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage is read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_meta_q <= 1'b1;
      rx_pin_q  <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd_in;
      rx_pin_q  <= rx_meta_q;
      if (sample_tick) begin
        rx_prev_q <= rx_pin_q;
      end
    end
  end

  // Receive sequencer; runs beside transmit for full duplex
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_st_q   <= RX_IDLE;
      rx_sr_q   <= `FMSP_NINE_RESET;
      rx_idx_q  <= 4'h0;
      rdiv_q    <= 4'h0;
      rsmp_q    <= 2'h0;
      rx_last_q <= 1'b0;
      m0_samp_q <= 1'b1;
      rx_buf_q  <= `FMSP_BYTE_RESET;
      rx_ninth_bit_q <= 1'b0;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          if (is_m0 && rx_enable_q && !rx_done_flag_q) begin
            rx_st_q <= RX_M0_ARM;
          end else if (!is_m0 && rx_enable_q && rx_fall) begin
            // Restart the divider to align with the incoming bits
            rx_st_q  <= RX_U_BIT;
            rdiv_q   <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_sr_q  <= `FMSP_NINE_ONES;
          end
        end
        RX_M0_ARM: begin
          if (at_s6p2) begin
            rx_sr_q   <= {1'b0, `FMSP_M0_RX_INIT};
            rx_st_q   <= RX_M0_RUN;
            rx_last_q <= 1'b0;
          end
        end
        RX_M0_RUN: begin
          if (at_s5p2) begin
            m0_samp_q <= rx_pin_q;
          end
          if (at_s6p2 && !rx_last_q) begin
            rx_sr_q[7:0] <= {rx_sr_q[6:0], m0_samp_q};
            if (!rx_sr_q[7]) begin
              // Zero reached the left end: last shift loads buffer
              rx_buf_q  <= rev8({rx_sr_q[6:0], m0_samp_q});
              rx_last_q <= 1'b1;
            end
          end else if (at_s1p1 && rx_last_q) begin
            rx_st_q   <= RX_IDLE;
            rx_last_q <= 1'b0;
          end
        end
        RX_U_BIT: begin
          if (sample_tick) begin
            rdiv_q <= rdiv_q + 4'h1;
            if (rdiv_q == `FMSP_SMP_FIRST) begin
              rsmp_q[0] <= rx_pin_q;
            end
            if (rdiv_q == `FMSP_SMP_SECOND) begin
              rsmp_q[1] <= rx_pin_q;
            end
          end
          if (rx_dec) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == 4'h0 && rx_bit) begin
              rx_st_q <= RX_IDLE;
            end else if (rx_idx_q != 4'h0 &&
                         rx_idx_q <= `FMSP_RX_NINTH_IDX) begin
              rx_sr_q <= rx_shift;
            end
            if (rx_end) begin
              rx_st_q <= RX_IDLE;
              if (rx_take) begin
                rx_buf_q       <= rx_frame[7:0];
                rx_ninth_bit_q <= rx_frame[8];
              end
            end
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txd_q      <= 1'b1;
      rxd_out_q  <= 1'b1;
      rxd_oe_b_q <= 1'b1;
    end else begin
      if (tx_st_q == TX_M0_SEND || rx_st_q == RX_M0_RUN) begin
        txd_q <= !clk_low;
      end else if (tx_st_q == TX_U_START) begin
        txd_q <= 1'b0;
      end else if (tx_st_q == TX_U_DATA) begin
        txd_q <= tx_sr_q[0];
      end else begin
        txd_q <= 1'b1;
      end
      rxd_out_q  <= tx_sr_q[0];
      rxd_oe_b_q <= (tx_st_q != TX_M0_SEND);
    end
  end

endmodule : fmsp_port

`default_nettype wire

// ### verification/fmsp_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fmsp_port_sva (
  input wire logic       clk,        // Clock
  input wire logic       rst_b,      // Reset, low
  input wire logic [1:0] reg_addr,   // Address
  input wire logic [7:0] reg_wdata,  // Write data
  input wire logic       reg_wr,     // Write strobe
  input wire logic       reg_rd,     // Read strobe
  input wire logic [7:0] reg_rdata,  // Read data
  input wire logic       t1_ovf,     // Overflow pulse
  input wire logic       rxd_in,     // Pin level
  input wire logic       rxd_out,    // Pin drive
  input wire logic       rxd_oe_b,   // Pin enable, low
  input wire logic       txd,        // Transmit pin
  input wire logic       serial_irq  // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] oe_cnt_q; // Cycles the pin has been driven
  // Count drive cycles; the send length is fixed by the bit count
  always_ff @(posedge clk) begin
    if (!rst_b || rxd_oe_b) oe_cnt_q <= 8'h00;
    else oe_cnt_q <= oe_cnt_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 2'h3 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_irq_flags: assert property (reg_rd && reg_addr == 2'h1 |=>
    (reg_rdata[1:0] != 2'h0) == $past(serial_irq))
    else $error("interrupt differs from flags");
  a_irq_holds: assert property (serial_irq &&
    !(reg_wr && reg_addr == 2'h1) |=> serial_irq)
    else $error("flag cleared without software");
  a_send_length: assert property ($rose(rxd_oe_b) |->
    oe_cnt_q inside {[8'h54:8'h62]}) else $error("send length wrong");
  a_clk_low_six: assert property ($fell(txd) && !rxd_oe_b |->
    !txd [*6] ##1 txd) else $error("shift clock low time wrong");
  a_clk_high_six: assert property ($rose(txd) && !rxd_oe_b |->
    txd [*6] ##1 (!txd || rxd_oe_b)) else $error("shift clock high wrong");
  a_send_done_irq: assert property ($rose(rxd_oe_b) |-> serial_irq)
    else $error("send ended without flag");
endmodule : fmsp_port_sva
bind fmsp_port fmsp_port_sva fmsp_port_sva_i (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t1_ovf(t1_ovf),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_b(rxd_oe_b), .txd(txd),
  .serial_irq(serial_irq));
`default_nettype wire

// ### verification/fmsp_remote.sv
`timescale 1ns/1ps
`default_nettype none
module fmsp_remote (
  input wire logic clk,      // Clock
  input wire logic txd,      // Device transmit pin
  input wire logic rxd_out,  // Device pin drive
  input wire logic rxd_oe_b, // Device pin enable, low
  output var logic line      // Our drive; idle high as a pull-up
);
  logic [7:0] m0_in;  // Byte captured from shift mode
  logic [7:0] m0_out; // Bits still to offer in shift mode
  logic       m0_on;  // Shift mode offering active
  initial begin
    line = 1'b1;
    m0_on = 1'b0;
  end
  // Shift mode: take data on clock rise, change ours after it
  always @(posedge txd) begin
    if (!rxd_oe_b) begin
      m0_in <= {rxd_out, m0_in[7:1]};
    end else if (m0_on) begin
      line <= m0_out[0];
      m0_out <= {1'b1, m0_out[7:1]};
    end
  end
  task automatic m0_load(input logic [7:0] b);
    line = b[0];
    m0_out = {1'b1, b[7:1]};
    m0_on = 1'b1;
  endtask : m0_load
  // Frame out, LSB first, 64 clocks a bit, then release
  task automatic uart_send(input int n, input logic [10:0] b);
    for (int i = 0; i < n; i++) begin
      line <= b[i];
      repeat (64) @(posedge clk);
    end
    line <= 1'b1;
  endtask : uart_send
  // Frame in, each bit taken at its middle
  task automatic uart_get(input int n, output logic [10:0] b);
    b = 11'h000;
    @(negedge txd);
    repeat (32) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      if (i < n - 1) repeat (64) @(posedge clk);
    end
  endtask : uart_get
endmodule : fmsp_remote
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_b, reg_wr, reg_rd, t1_ovf; // Bench drives
  logic [1:0] reg_addr;    // Address
  logic [7:0] reg_wdata, q; // Write data, read result
  logic [10:0] fr;         // Captured frame
  wire logic [7:0] reg_rdata; // Read data
  wire logic rxd_in, rxd_out, rxd_oe_b, txd, serial_irq, line;
  int mismatches, tests_run, cyc, per, t1c;
  always #2.5 clk = ~clk;
  // Pin level from both parties' drives
  assign rxd_in = rxd_oe_b ? line : rxd_out;
  fmsp_port fmsp_port_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .t1_ovf(t1_ovf), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe_b(rxd_oe_b), .txd(txd),
    .serial_irq(serial_irq));
  fmsp_remote fmsp_remote_i (.clk(clk), .txd(txd), .rxd_out(rxd_out),
    .rxd_oe_b(rxd_oe_b), .line(line));
  // Timer overflow stand-in; its rate sets the variable modes
  always @(posedge clk) begin
    t1c <= (t1c + 1) % per;
    t1_ovf <= (t1c == 0);
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [10:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_irq;
    for (int i = 0; i < 2000 && serial_irq !== 1'b1; i++) @(posedge clk);
    chk("irq", serial_irq, 11'h001);
  endtask : wait_irq
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst_b = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; t1_ovf = 0;
    reg_wdata = 0; per = 2; t1c = 0; cyc = 0; mismatches = 0; tests_run = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(1, q); chk("control reset", q, 8'h00);
    rd(2, q); chk("power reset", q, 8'h00);
    wr(1, 8'h0F); rd(1, q); chk("control rw", q, 8'h0B);
    rd(3, q); chk("unmapped", q, 8'h00);
    wr(1, 8'h00); $display("test registers done"); // Filter kept 0
    wr(0, 8'hA5); wait_irq;
    chk("shift tx", fmsp_remote_i.m0_in, 8'hA5);
    rd(1, q); chk("shift tx flag", q, 8'h02);
    wr(1, 8'h00); fmsp_remote_i.m0_load(8'h3C); wr(1, 8'h10); wait_irq;
    rd(0, q); chk("shift rx", q, 8'h3C);
    rd(1, q); chk("shift rx flag", q, 8'h11);
    wr(1, 8'h00); fmsp_remote_i.m0_on = 1'b0; $display("test shift done");
    for (int m = 1; m < 4; m++) begin
      per = (m == 3) ? 4 : 2; // 64 clocks a bit in every mode
      wr(2, (m == 3) ? 8'h80 : 8'h00);
      wr(1, {m[1:0], 6'h18});
      fork
        begin
          wr(0, 8'h96 ^ m[7:0]);
          fmsp_remote_i.uart_get((m == 1) ? 10 : 11, fr);
        end
        fmsp_remote_i.uart_send(11, {2'b11, ~(8'h96 ^ m[7:0]), 1'b0});
      join
      chk("uart tx", fr, {m != 1, 1'b1, 8'h96 ^ m[7:0],
        1'b0});
      // Cast keeps the inversion at byte width against the 8-bit read
      rd(0, q); chk("uart rx", q, 8'(~(8'h96 ^ m[7:0])));
      rd(1, q); chk("uart flags", q, {m[1:0], 6'h1F});
      $display("test uart mode %0d done", m);
    end
    wr(1, 8'hC0); fmsp_remote_i.uart_send(11, {2'b11, 8'h44, 1'b0});
    // Received ninth bit is read-only and still holds the last frame's one
    rd(1, q); chk("rx disabled", q, 8'hC4);
    wr(1, 8'hF0); fmsp_remote_i.uart_send(11, {2'b10, 8'h55, 1'b0});
    rd(1, q); chk("filter data", q, 8'hF4);
    fmsp_remote_i.uart_send(11, {2'b11, 8'h66, 1'b0});
    rd(1, q); chk("filter addr", q, 8'hF5);
    rd(0, q); chk("filter byte", q, 8'h66);
    $display("test filter done");
    per = 2; wr(2, 8'h00); wr(1, 8'h70); // Mode 1, filter, receive on
    fmsp_remote_i.uart_send(11, {2'b10, 8'h77, 1'b0}); // Stop bit zero
    rd(1, q); chk("bad stop", q, 8'h74);
    fmsp_remote_i.uart_send(11, {2'b11, 8'h77, 1'b0});
    rd(1, q); chk("good stop", q, 8'h75);
    fmsp_remote_i.uart_send(11, {2'b11, 8'h11, 1'b0}); // Flag still set
    rd(0, q); chk("overrun keeps", q, 8'h77);
    $display("test stop filter done");
    conclude();
  end
endmodule : tb
`default_nettype wire
